/* File: verilog/ssx_exec.sv */
// Decode and execute for halt, literal-minus-acc and file-minus-acc.
// Assumes one program word per valid cycle; flags, watchdog and file live outside.
`timescale 1ns/100ps
`default_nettype none
module ssx_exec (
    input wire logic CLK, // 50 MHz core clock
    input wire logic RESET_N, // Async reset, low
    input wire logic INSTR_VALID, // Program word present
    input wire logic [13:0] INSTR, // Program word
    input wire logic [7:0] ACC_IN, // Current accumulator
    input wire logic [7:0] FILE_RDATA, // Addressed file register
    input wire logic WAKE, // Wake-up event
    output logic [6:0] FILE_ADDR, // File register index
    output logic [7:0] RESULT, // Write-back data
    output logic ACC_WE, // Accumulator write pulse
    output logic FILE_WE, // File write pulse
    output logic [6:0] FILE_WADDR, // File write index
    output logic FLAG_WE, // Arith flags update pulse
    output logic CARRY_FLAG, // Borrow-not
    output logic HALF_BORROW_FLAG, // Nibble borrow-not
    output logic ZERO_FLAG, // Zero result
    output logic WDT_CLEAR, // Watchdog and prescaler clear pulse
    output logic [7:0] WATCHDOG_COUNTER_LOAD, // Watchdog load value
    output logic SLEEP_FLAGS_WE, // Expiry/powerdown update pulse
    output logic EXPIRY_FLAG, // Expiry flag value
    output logic POWERDOWN_FLAG, // Powerdown flag value
    output logic OSC_STOP, // Oscillator stop request
    output logic FETCH_EN // Fetch permitted
);

    ////////////////////////////////////////////////////////////////////////
    // Decode

    function automatic logic is_match(input logic [13:0] w, input logic [13:0] m,
                                      input logic [13:0] c);
        is_match = ((w & m) == c);
    endfunction

    logic halt_hit, subl_hit, subf_hit, dest_file;
    logic [7:0] minuend;

    always_comb begin
        halt_hit = INSTR_VALID && (INSTR == ssx_pkg::HALT_OPC);
        // Bit 8 left out of the mask on purpose
        subl_hit = INSTR_VALID
            && is_match(INSTR, ssx_pkg::SUBL_MASK, ssx_pkg::SUBL_CODE);
        subf_hit = INSTR_VALID
            && is_match(INSTR, ssx_pkg::SUBF_MASK, ssx_pkg::SUBF_CODE);
        dest_file = INSTR[ssx_pkg::DEST_BIT];
        // Literal taken unsigned from low byte
        minuend = subl_hit ? INSTR[ssx_pkg::LIT_MSB:0] : FILE_RDATA;
    end

    // Address goes out combinationally-free: both indexes are registered below,
    // the read port from the live field every cycle and the write one only on file-minus-acc.
    logic [6:0] addr_live;
    assign addr_live = INSTR[ssx_pkg::ADR_MSB:0];

    ////////////////////////////////////////////////////////////////////////
    // Subtractor

    logic alu_en;
    logic [7:0] diff;
    logic c_f, h_f, z_f;
    ssx_pkg::ssx_state_t state_reg, state_next;

    assign alu_en = (state_reg == ssx_pkg::ST_RUN) && (subl_hit || subf_hit);

    ssx_alu u_alu (
        .clk(CLK),
        .reset_n(RESET_N),
        .en(alu_en),
        .a(minuend),
        .b(ACC_IN),
        .diff_reg(diff),
        .carry_reg(c_f),
        .half_reg(h_f),
        .zero_reg(z_f)
    );

    ////////////////////////////////////////////////////////////////////////
    // Control state

    logic acc_we_reg, acc_we_next, file_we_reg, file_we_next, flag_we_reg, flag_we_next;
    logic wdt_clr_reg, wdt_clr_next, sfl_we_reg, sfl_we_next;
    logic fetch_reg, fetch_next, osc_reg, osc_next;
    logic [6:0] waddr_reg, waddr_next, raddr_reg, raddr_next;

    always_comb begin
        state_next = state_reg;
        acc_we_next = 1'b0;
        file_we_next = 1'b0;
        flag_we_next = 1'b0;
        wdt_clr_next = 1'b0;
        sfl_we_next = 1'b0;
        fetch_next = fetch_reg;
        osc_next = osc_reg;
        waddr_next = waddr_reg;
        raddr_next = addr_live;
        case (state_reg)
            ssx_pkg::ST_RUN: begin
                if (halt_hit) begin
                    wdt_clr_next = 1'b1;
                    sfl_we_next = 1'b1;
                    fetch_next = 1'b0;
                    osc_next = 1'b1;
                    state_next = ssx_pkg::ST_HALT;
                end else if (subl_hit) begin
                    acc_we_next = 1'b1;
                    flag_we_next = 1'b1;
                end else if (subf_hit) begin
                    acc_we_next = !dest_file;
                    file_we_next = dest_file;
                    flag_we_next = 1'b1;
                    waddr_next = addr_live;
                end
            end
            ssx_pkg::ST_HALT: begin
                // Everything else is ignored while halted
                if (WAKE) begin
                    fetch_next = 1'b1;
                    osc_next = 1'b0;
                    state_next = ssx_pkg::ST_RUN;
                end
            end
            default: begin
                state_next = ssx_pkg::ST_RUN;
                fetch_next = 1'b1;
                osc_next = 1'b0;
            end
        endcase
    end

    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            state_reg <= ssx_pkg::ST_RUN;
            acc_we_reg <= 1'b0;
            file_we_reg <= 1'b0;
            flag_we_reg <= 1'b0;
            wdt_clr_reg <= 1'b0;
            sfl_we_reg <= 1'b0;
            fetch_reg <= 1'b1;
            osc_reg <= 1'b0;
            waddr_reg <= 7'h00;
            raddr_reg <= 7'h00;
        end else begin
            state_reg <= state_next;
            acc_we_reg <= acc_we_next;
            file_we_reg <= file_we_next;
            flag_we_reg <= flag_we_next;
            wdt_clr_reg <= wdt_clr_next;
            sfl_we_reg <= sfl_we_next;
            fetch_reg <= fetch_next;
            osc_reg <= osc_next;
            waddr_reg <= waddr_next;
            raddr_reg <= raddr_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs, from flip-flops or package constants

    assign FILE_ADDR = raddr_reg;
    assign RESULT = diff;
    assign ACC_WE = acc_we_reg;
    assign FILE_WE = file_we_reg;
    assign FILE_WADDR = waddr_reg;
    assign FLAG_WE = flag_we_reg;
    assign CARRY_FLAG = c_f;
    assign HALF_BORROW_FLAG = h_f;
    assign ZERO_FLAG = z_f;
    assign WDT_CLEAR = wdt_clr_reg;
    assign WATCHDOG_COUNTER_LOAD = ssx_pkg::WDT_CLEAR_VAL;
    assign SLEEP_FLAGS_WE = sfl_we_reg;
    assign EXPIRY_FLAG = ssx_pkg::EXPIRY_ON_HALT;
    assign POWERDOWN_FLAG = ssx_pkg::POWERDOWN_ON_HALT;
    assign OSC_STOP = osc_reg;
    assign FETCH_EN = fetch_reg;
endmodule
`default_nettype wire

/* File: verilog/ssx_pkg.sv */
// Constants for the halt and subtract decode/execute block.
// Assumes an 8-bit core with 14-bit program words and 7-bit file addresses.
package ssx_pkg;
    localparam int OPC_W = 14;
    localparam int DAT_W = 8;
    localparam int ADR_W = 7;
    // Opcodes and decode masks
    localparam logic [13:0] HALT_OPC = 14'h0063;
    localparam logic [13:0] SUBL_MASK = 14'h3E00;
    localparam logic [13:0] SUBL_CODE = 14'h3C00;
    localparam logic [13:0] SUBF_MASK = 14'h3F00;
    localparam logic [13:0] SUBF_CODE = 14'h0200;
    // Field positions
    localparam int DEST_BIT = 7;
    localparam int LIT_MSB = 7;
    localparam int ADR_MSB = 6;
    localparam int HALF_BIT = 4;
    // Values written by the halt instruction
    localparam logic [7:0] WDT_CLEAR_VAL = 8'h00;
    localparam logic EXPIRY_ON_HALT = 1'b1;
    localparam logic POWERDOWN_ON_HALT = 1'b0;
    typedef enum logic [1:0] {
        ST_RUN = 2'h1,
        ST_HALT = 2'h2
    } ssx_state_t;
endpackage

/* File: verilog/ssx_alu.sv */
// Registered subtractor: a minus b with borrow-not, half-borrow and zero.
// Assumes operands are stable in the cycle the enable is high.
`timescale 1ns/100ps
`default_nettype none
module ssx_alu (
    input wire logic clk, // Core clock
    input wire logic reset_n, // Async reset, low
    input wire logic en, // Capture result
    input wire logic [7:0] a, // Minuend
    input wire logic [7:0] b, // Subtrahend
    output logic [7:0] diff_reg, // Difference
    output logic carry_reg, // Borrow-not
    output logic half_reg, // Nibble borrow-not
    output logic zero_reg // Result zero
);
    logic [8:0] sum;
    logic [4:0] low;
    logic [7:0] diff_next;
    logic carry_next, half_next, zero_next;

    always_comb begin
        // Two's complement: a + ~b + 1
        sum = {1'b0, a} + {1'b0, ~b} + 9'h001;
        low = {1'b0, a[3:0]} + {1'b0, ~b[3:0]} + 5'h01;
        diff_next = diff_reg;
        carry_next = carry_reg;
        half_next = half_reg;
        zero_next = zero_reg;
        if (en) begin
            diff_next = sum[7:0];
            carry_next = sum[8];
            half_next = low[ssx_pkg::HALF_BIT];
            zero_next = (sum[7:0] == 8'h00);
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            diff_reg <= 8'h00;
            carry_reg <= 1'b0;
            half_reg <= 1'b0;
            zero_reg <= 1'b0;
        end else begin
            diff_reg <= diff_next;
            carry_reg <= carry_next;
            half_reg <= half_next;
            zero_reg <= zero_next;
        end
    end
endmodule
`default_nettype wire

/* File: test/ssx_exec_assertions.sv */
// Checker for the halt and subtract execute block.
// Assumes it is bound to ssx_exec and sees only its ports.
`timescale 1ns/100ps
`default_nettype none
module ssx_exec_chk (
    input wire logic CLK, // Clock
    input wire logic RESET_N, // Reset
    input wire logic INSTR_VALID, // Valid
    input wire logic [13:0] INSTR, // Word
    input wire logic [7:0] ACC_IN, // Acc
    input wire logic [7:0] FILE_RDATA, // File data
    input wire logic WAKE, // Wake
    input wire logic [7:0] RESULT, // Result
    input wire logic ACC_WE, // Acc write
    input wire logic FILE_WE, // File write
    input wire logic [6:0] FILE_WADDR, // File index
    input wire logic FLAG_WE, // Flag write
    input wire logic CARRY_FLAG, // Borrow-not
    input wire logic HALF_BORROW_FLAG, // Half
    input wire logic ZERO_FLAG, // Zero
    input wire logic WDT_CLEAR, // Clear
    input wire logic [7:0] WATCHDOG_COUNTER_LOAD, // Load
    input wire logic SLEEP_FLAGS_WE, // Flag load
    input wire logic EXPIRY_FLAG, // Expiry
    input wire logic POWERDOWN_FLAG, // Powerdown
    input wire logic OSC_STOP, // Stopped
    input wire logic FETCH_EN // Fetching
);
////////////////////////////////////////
// Decode kept apart from the package masks so a mask slip shows
logic run_ok, halt_go, lit_go, file_go, sub_go, cy_ok, half_ok;
logic [7:0] opa, diff;
assign run_ok = INSTR_VALID && FETCH_EN;
assign halt_go = run_ok && INSTR == 14'h0063;
assign lit_go = run_ok && INSTR[13:9] == 5'h1E;
assign file_go = run_ok && INSTR[13:8] == 6'h02;
assign sub_go = lit_go || file_go;
assign opa = INSTR[13] ? INSTR[7:0] : FILE_RDATA;
assign diff = opa - ACC_IN;
assign cy_ok = opa >= ACC_IN;
assign half_ok = opa[3:0] >= ACC_IN[3:0];
default clocking cb @(posedge CLK); endclocking
default disable iff (!RESET_N);
////////////////////////////////////////
chk_halt_effects: assert property (halt_go |=> WDT_CLEAR && SLEEP_FLAGS_WE &&
    WATCHDOG_COUNTER_LOAD == 8'h00 && EXPIRY_FLAG && !POWERDOWN_FLAG) else $error("halt effects");
chk_halt_stop: assert property (halt_go |=> OSC_STOP && !FETCH_EN)
    else $error("halt did not stop");
chk_wake_resume: assert property (OSC_STOP && WAKE |=> FETCH_EN && !OSC_STOP)
    else $error("wake ignored");
chk_sub_result: assert property (sub_go |=> FLAG_WE && RESULT == $past(diff))
    else $error("difference wrong");
chk_lit_dest: assert property (lit_go |=> ACC_WE && !FILE_WE)
    else $error("literal dest wrong");
chk_file_dest: assert property (file_go |=> FILE_WE == $past(INSTR[7]) && ACC_WE != FILE_WE)
    else $error("file dest wrong");
chk_file_index: assert property (file_go ##1 FILE_WE |-> FILE_WADDR == $past(INSTR[6:0]))
    else $error("file index wrong");
chk_borrow_flag: assert property (sub_go |=> CARRY_FLAG == $past(cy_ok))
    else $error("borrow flag wrong");
chk_zero_half: assert property (sub_go |=> ZERO_FLAG == (RESULT == 8'h00) &&
    HALF_BORROW_FLAG == $past(half_ok)) else $error("zero or half flag wrong");
chk_no_stray: assert property (!(halt_go || sub_go) |=> !ACC_WE && !FILE_WE &&
    !FLAG_WE && !WDT_CLEAR) else $error("stray pulse");
endmodule
bind ssx_exec ssx_exec_chk ssx_exec_chk_i (.CLK, .RESET_N, .INSTR_VALID, .INSTR, .ACC_IN,
    .FILE_RDATA, .WAKE, .RESULT, .ACC_WE, .FILE_WE, .FILE_WADDR, .FLAG_WE, .CARRY_FLAG,
    .HALF_BORROW_FLAG, .ZERO_FLAG, .WDT_CLEAR, .WATCHDOG_COUNTER_LOAD, .SLEEP_FLAGS_WE,
    .EXPIRY_FLAG, .POWERDOWN_FLAG, .OSC_STOP, .FETCH_EN);
`default_nettype wire

/* File: test/ssx_exec_test.sv */
// Self-checking bench for the halt and subtract execute block.
// Assumes the checker is bound in from its own file.
`timescale 1ns/100ps
`default_nettype none
module ssx_exec_test;
logic clk = 1'b0, reset_n = 1'b0, valid = 1'b0, wake = 1'b0;
logic [13:0] instr = 14'h0000;
logic [7:0] acc = 8'h00, fdat = 8'h00, result, wload;
logic [6:0] waddr, faddr;
logic acc_we, file_we, flag_we, cy, hf, zf, wclr, swe, expf, pdf, osc, fen;
int checks = 0, miscompares = 0, cycles = 0;
logic [7:0] kv [5] = '{8'h02, 8'h02, 8'h02, 8'hFF, 8'h00};
logic [7:0] wv [5] = '{8'h01, 8'h02, 8'h03, 8'h00, 8'h01};
ssx_exec ssx_exec_i (.CLK(clk), .RESET_N(reset_n), .INSTR_VALID(valid), .INSTR(instr),
    .ACC_IN(acc), .FILE_RDATA(fdat), .WAKE(wake), .FILE_ADDR(faddr), .RESULT(result),
    .ACC_WE(acc_we), .FILE_WE(file_we), .FILE_WADDR(waddr), .FLAG_WE(flag_we),
    .CARRY_FLAG(cy), .HALF_BORROW_FLAG(hf), .ZERO_FLAG(zf), .WDT_CLEAR(wclr),
    .WATCHDOG_COUNTER_LOAD(wload), .SLEEP_FLAGS_WE(swe), .EXPIRY_FLAG(expf),
    .POWERDOWN_FLAG(pdf), .OSC_STOP(osc), .FETCH_EN(fen));
always #10 clk = ~clk;
////////////////////////////////////////
task automatic report_and_stop();
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) begin
        $display("Finished cleanly");
    end else begin
        $display("Finished with errors");
    end
    $finish;
endtask
always @(posedge clk) begin
    cycles++;
    if (cycles == 500) begin
        miscompares++;
        report_and_stop();
    end
end
task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
        miscompares++;
        $display("unexpected at %0t: got %0h expected %0h", $time, got, exp);
    end
endtask
// One word in one cycle, outputs judged after the capture edge
task automatic op(input logic [13:0] w, input logic [7:0] a, input logic [7:0] f);
    @(posedge clk) #2;
    valid = 1'b1;
    instr = w;
    acc = a;
    fdat = f;
    @(posedge clk) #2;
    valid = 1'b0;
endtask
task automatic sub_chk(input logic [7:0] a, input logic [7:0] b);
    chk(result, 8'(a - b));
    chk({5'h00, cy, hf, zf}, {5'h00, a >= b, a[3:0] >= b[3:0], a == b});
endtask
////////////////////////////////////////
task automatic t_lit();
    for (int i = 0; i < 5; i++) begin
        op({5'h1E, i[0], kv[i]}, wv[i], 8'hA5);
        sub_chk(kv[i], wv[i]);
        chk({5'h00, acc_we, file_we, flag_we}, 8'h05);
    end
endtask
task automatic t_file();
    for (int i = 0; i < 5; i++) begin
        op({6'h02, i[0], 7'(127 - i)}, wv[i], kv[i]);
        sub_chk(kv[i], wv[i]);
        chk({6'h00, acc_we, file_we}, {6'h00, ~i[0], i[0]});
        if (i[0]) chk({1'b0, waddr}, 8'(127 - i));
        chk({1'b0, faddr}, 8'(127 - i));
    end
endtask
task automatic t_bad();
    logic [13:0] bad [4] = '{14'h0064, 14'h0062, 14'h3E00, 14'h0300};
    for (int i = 0; i < 4; i++) begin
        op(bad[i], 8'h01, 8'h01);
        chk({4'h0, acc_we, file_we, flag_we, wclr}, 8'h00);
    end
endtask
task automatic t_halt();
    op(14'h0063, 8'h00, 8'h00);
    chk({2'b00, wclr, swe, expf, pdf, osc, fen}, 8'h3A);
    chk(wload, 8'h00);
    op(14'h3C05, 8'h03, 8'h00);
    chk({5'h00, acc_we, wclr, fen}, 8'h00);
    @(posedge clk) #2;
    wake = 1'b1;
    @(posedge clk) #2;
    wake = 1'b0;
    chk({6'h00, osc, fen}, 8'h01);
endtask
initial begin
    repeat (4) @(posedge clk);
    #2;
    reset_n = 1'b1;
    t_lit();
    t_file();
    t_bad();
    t_halt();
    t_lit();
    report_and_stop();
end
endmodule
`default_nettype wire
